// ---- spg_pkg.sv ----
// Shared constants for the serial port glue logic.
package spg_pkg;
    // Register map, byte addresses on the APB.
    localparam logic [7:0] SPG_CFG_OFFSET = 8'h00;
    localparam logic [7:0] SPG_STATUS_OFFSET = 8'h04;
    localparam logic [7:0] SPG_CFG_RESET = 8'h00;
    // Configuration field positions.
    localparam int SPG_CFG_A_MODE_LSB = 2;
    localparam int SPG_CFG_B_MODE_LSB = 0;
    localparam int SPG_CFG_RATE_LSB = 5;
    // Status field positions.
    localparam int SPG_ST_PENDING = 0;
    localparam int SPG_ST_INT_LEVEL = 1;
    localparam int SPG_ST_ACK = 2;
    localparam int SPG_ST_CFG_LSB = 8;
    // Clock modes of one channel.
    localparam logic [1:0] SPG_MODE_SYNC = 2'h0;
    localparam logic [1:0] SPG_MODE_ASYNC = 2'h1;
    localparam logic [1:0] SPG_MODE_SPLIT = 2'h2;
    // Processor bus decode.
    localparam logic [7:0] SPG_WINDOW_HI = 8'h60;
    localparam logic [2:0] SPG_FC_SUP_DATA = 3'h5;
    localparam logic [2:0] SPG_FC_SUP_PROG = 3'h6;
    localparam logic [2:0] SPG_FC_CPU_SPACE = 3'h7;
    localparam logic [2:0] SPG_IRQ_LEVEL = 3'h5;
    // Timing.
    localparam longint SPG_PCLK_HZ = 200000000;
    localparam longint SPG_LOCAL_OSC_HZ = 4915000;
    localparam longint SPG_LOCAL_PRESCALE = 8;
    localparam longint SPG_ASYNC_CLK_HZ = 3686400;
    localparam int SPG_RATE_COUNT = 8;
    localparam int SPG_OSC_DIV_CYC = int'(SPG_PCLK_HZ / (SPG_LOCAL_OSC_HZ / SPG_LOCAL_PRESCALE));
    localparam int SPG_ASYNC_HALF_CYC = int'(SPG_PCLK_HZ / (2 * SPG_ASYNC_CLK_HZ));
endpackage : spg_pkg

// ---- spg_baud_if.sv ----
// Interface between the glue top and its baud clock generator.
`timescale 1ns/1ps
`default_nettype none
interface spg_baud_if;
    logic [2:0] rate_sel;
    logic tx_tick;
    logic async_tick;
    modport gen (input rate_sel, output tx_tick, output async_tick);
    modport user (output rate_sel, input tx_tick, input async_tick);
endinterface : spg_baud_if
`default_nettype wire

// ---- spg_baud_gen.sv ----
// Baud and asynchronous clock enable generator.
`timescale 1ns/1ps
`default_nettype none
module spg_baud_gen
    import spg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    spg_baud_if.gen bif
);
    typedef struct packed {
        logic [8:0] pre_cnt;
        logic [7:0] div_cnt;
        logic [4:0] async_cnt;
        logic tx_tick;
        logic async_tick;
    } spg_gen_state_type;

    spg_gen_state_type r;
    spg_gen_state_type n;
    logic [SPG_RATE_COUNT-1:0] taps;

    // Each tap fires at half the rate of the one below it, as a binary counter does.
    for (genvar k = 0; k < SPG_RATE_COUNT; k++)
    begin : g_tap
        if (k == 0)
        begin : g_first
            assign taps[k] = 1'b1;
        end
        else
        begin : g_rest
            assign taps[k] = &r.div_cnt[k-1:0];
        end
    end

    always_comb
    begin
        n = r;
        n.tx_tick = 1'b0;
        n.async_tick = 1'b0;
        if (r.pre_cnt == 9'(SPG_OSC_DIV_CYC - 1))
        begin
            n.pre_cnt = 9'h000;
            n.div_cnt = r.div_cnt + 8'h01;
            n.tx_tick = taps[bif.rate_sel];
        end
        else
        begin
            n.pre_cnt = r.pre_cnt + 9'h001;
        end
        if (r.async_cnt == 5'(SPG_ASYNC_HALF_CYC - 1))
        begin
            n.async_cnt = 5'h00;
            n.async_tick = 1'b1;
        end
        else
        begin
            n.async_cnt = r.async_cnt + 5'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end

    assign bif.tx_tick = r.tx_tick;
    assign bif.async_tick = r.async_tick;
endmodule : spg_baud_gen
`default_nettype wire

// ---- spg_glue.sv ----
// Top of the serial port glue logic: decode, strobes, interrupt and clock select.
//
// How it works
// - Controller select only on supervisor read or write inside window 60XXXY.
// - Channel select address bit high picks channel A, low picks B.
// - Data or control address bit passed to controller each access.
// - Read and write strobes gated with board timing phase before reaching controller.
// - Board reset drives both controller strobes active together.
// - Controller pulls its interrupt low when a byte moves buffer to shift.
// - Low controller interrupt puts level 5 on active-low priority lines.
// - Acknowledge with level 5 drives autovector valid low.
// - Level 5 acknowledge registered on system clock and driven to controller.
// - Config bits 3:2 pick channel A clock mode; bits 1:0 ignored there.
// - Config bits 1:0 pick channel B clock mode; bits 3:2 ignored there.
// - Config bits 7:5 pick transmit rate 19,200 halving to 150; bit 4 ignored.
// - Oscillator divided by 8, then eight rates at sixteen times baud.
// - Asynchronous mode routes the fixed local clock to the channel.
// - Synchronous mode routes the external connector clock to the channel.
`timescale 1ns/1ps
`default_nettype none
module spg_glue
    import spg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpu_as_n,
    input wire logic cpu_read,
    input wire logic [2:0] cpu_fc,
    input wire logic [23:1] cpu_addr,
    input wire logic strobe_timing_phase,
    input wire logic board_reset_line,
    input wire logic scc_int_n,
    input wire logic ext_chan_a_clock,
    input wire logic ext_chan_b_clock,
    output logic scc_cs_n,
    output logic channel_select_addr_bit,
    output logic data_control_addr_bit,
    output logic scc_rd_n,
    output logic scc_wr_n,
    output logic priority_line0_n,
    output logic priority_line1_n,
    output logic priority_line2_n,
    output logic autovector_valid_n,
    output logic level5_ack_n,
    output logic chan_a_clk,
    output logic chan_b_clk
);
    typedef struct packed {
        logic as_n;
        logic rd;
        logic [2:0] fc;
        logic [23:1] addr;
        logic phase;
        logic brst;
        logic int_n;
        logic [1:0] ext_clk;
    } spg_pins_type;

    typedef struct packed {
        spg_pins_type s1;
        spg_pins_type s2;
        logic [7:0] cfg;
        logic pending;
        logic ack_n;
        logic cs_n;
        logic chan_sel;
        logic dc_sel;
        logic rd_n;
        logic wr_n;
        logic [2:0] ipl_n;
        logic vpa_n;
        logic [1:0] chan_clk;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } spg_state_type;

    spg_state_type r;
    spg_state_type n;
    spg_pins_type pin;
    logic sel;
    logic iack5;
    logic wr_done;
    logic [1:0] mode [2];
    spg_baud_if bif ();

    spg_baud_gen u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .bif(bif)
    );

    assign bif.rate_sel = r.cfg[SPG_CFG_RATE_LSB +: 3];
    assign mode[0] = r.cfg[SPG_CFG_A_MODE_LSB +: 2];
    assign mode[1] = r.cfg[SPG_CFG_B_MODE_LSB +: 2];

    always_comb
    begin
        pin.as_n = cpu_as_n;
        pin.rd = cpu_read;
        pin.fc = cpu_fc;
        pin.addr = cpu_addr;
        pin.phase = strobe_timing_phase;
        pin.brst = board_reset_line;
        pin.int_n = scc_int_n;
        pin.ext_clk = {ext_chan_b_clock, ext_chan_a_clock};
    end

    // Only the second synchroniser stage feeds any decode.
    assign sel = !r.s2.as_n && (r.s2.fc == SPG_FC_SUP_DATA || r.s2.fc == SPG_FC_SUP_PROG)
        && r.s2.addr[23:16] == SPG_WINDOW_HI;
    assign iack5 = !r.s2.as_n && r.s2.fc == SPG_FC_CPU_SPACE
        && r.s2.addr[3:1] == SPG_IRQ_LEVEL;
    assign wr_done = psel && penable && r.ready && pwrite;

    always_comb
    begin
        n = r;
        n.s1 = pin;
        n.s2 = r.s1;
        n.cs_n = !sel;
        n.chan_sel = r.s2.addr[2];
        n.dc_sel = r.s2.addr[1];
        // The phase gate keeps strobe edges clean for the controller timing.
        n.rd_n = !(sel && r.s2.rd && r.s2.phase);
        n.wr_n = !(sel && !r.s2.rd && r.s2.phase);
        if (r.s2.brst)
        begin
            n.rd_n = 1'b0;
            n.wr_n = 1'b0;
        end
        n.vpa_n = !iack5;
        n.ack_n = !iack5;
        // A new low on the controller line wins over the clearing acknowledge.
        if (!r.s2.int_n)
        begin
            n.pending = 1'b1;
        end
        else if (!r.ack_n)
        begin
            n.pending = 1'b0;
        end
        n.ipl_n = r.pending ? ~SPG_IRQ_LEVEL : 3'h7;
        for (int c = 0; c < 2; c++)
        begin
            unique case (mode[c])
                SPG_MODE_SYNC: n.chan_clk[c] = r.s2.ext_clk[c];
                SPG_MODE_ASYNC: n.chan_clk[c] = r.chan_clk[c] ^ bif.async_tick;
                SPG_MODE_SPLIT: n.chan_clk[c] = r.chan_clk[c] ^ bif.tx_tick;
                default: n.chan_clk[c] = 1'b0;
            endcase
        end
        // One wait state: ready rises in the second access cycle, falls after.
        n.ready = 1'b0;
        n.slverr = 1'b0;
        n.rdata = 32'h00000000;
        if (psel && penable && !r.ready)
        begin
            n.ready = 1'b1;
            if (paddr == SPG_STATUS_OFFSET)
            begin
                if (!pwrite)
                begin
                    n.rdata[SPG_ST_PENDING] = r.pending;
                    n.rdata[SPG_ST_INT_LEVEL] = !r.s2.int_n;
                    n.rdata[SPG_ST_ACK] = !r.ack_n;
                    n.rdata[SPG_ST_CFG_LSB +: 8] = r.cfg;
                end
            end
            else if (paddr != SPG_CFG_OFFSET)
            begin
                n.slverr = 1'b1;
            end
        end
        if (wr_done && paddr == SPG_CFG_OFFSET)
        begin
            n.cfg = pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
            r.cfg <= SPG_CFG_RESET;
            r.ack_n <= 1'b1;
            r.cs_n <= 1'b1;
            r.rd_n <= 1'b1;
            r.wr_n <= 1'b1;
            r.ipl_n <= 3'h7;
            r.vpa_n <= 1'b1;
            r.s1.as_n <= 1'b1;
            r.s2.as_n <= 1'b1;
            r.s1.int_n <= 1'b1;
            r.s2.int_n <= 1'b1;
        end
        else
        begin
            r <= n;
        end
    end

    assign prdata = r.rdata;
    assign pready = r.ready;
    assign pslverr = r.slverr;
    assign scc_cs_n = r.cs_n;
    assign channel_select_addr_bit = r.chan_sel;
    assign data_control_addr_bit = r.dc_sel;
    assign scc_rd_n = r.rd_n;
    assign scc_wr_n = r.wr_n;
    assign priority_line0_n = r.ipl_n[0];
    assign priority_line1_n = r.ipl_n[1];
    assign priority_line2_n = r.ipl_n[2];
    assign autovector_valid_n = r.vpa_n;
    assign level5_ack_n = r.ack_n;
    assign chan_a_clk = r.chan_clk[0];
    assign chan_b_clk = r.chan_clk[1];
endmodule : spg_glue
`default_nettype wire

// ---- spg_glue_assertions.sv ----
// Checker for the serial port glue top.
`timescale 1ns/1ps
`default_nettype none
module spg_glue_assertions
    import spg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cpu_as_n,
    input wire logic cpu_read,
    input wire logic [2:0] cpu_fc,
    input wire logic [23:1] cpu_addr,
    input wire logic strobe_timing_phase,
    input wire logic board_reset_line,
    input wire logic scc_int_n,
    input wire logic scc_cs_n,
    input wire logic channel_select_addr_bit,
    input wire logic data_control_addr_bit,
    input wire logic scc_rd_n,
    input wire logic scc_wr_n,
    input wire logic priority_line0_n,
    input wire logic priority_line1_n,
    input wire logic priority_line2_n,
    input wire logic autovector_valid_n,
    input wire logic level5_ack_n
);
    // Processor pins reach the outputs three clocks late, hence the depth of three.
    wire sel_c = !cpu_as_n && cpu_addr[23:16] == SPG_WINDOW_HI
        && (cpu_fc == SPG_FC_SUP_DATA || cpu_fc == SPG_FC_SUP_PROG);
    wire ack_c = !cpu_as_n && cpu_fc == SPG_FC_CPU_SPACE && cpu_addr[3:1] == SPG_IRQ_LEVEL;
    wire ph = strobe_timing_phase;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_sel_window: assert property (scc_cs_n == !$past(sel_c, 3))
        else $error("select wrong");
    a_chan_bit: assert property (!scc_cs_n |-> channel_select_addr_bit == $past(cpu_addr[2], 3))
        else $error("channel bit wrong");
    a_dc_bit: assert property (!scc_cs_n |-> data_control_addr_bit == $past(cpu_addr[1], 3))
        else $error("data bit wrong");
    a_rd_strobe: assert property (scc_rd_n == !$past(board_reset_line || sel_c && cpu_read && ph, 3))
        else $error("read strobe wrong");
    a_wr_strobe: assert property (scc_wr_n == !$past(board_reset_line || sel_c && !cpu_read && ph, 3))
        else $error("write strobe wrong");
    a_int_level: assert property ($fell(scc_int_n) |-> ##[2:6]
        {priority_line2_n, priority_line1_n, priority_line0_n} == 3'h2)
        else $error("level not shown");
    a_avec_ack: assert property (autovector_valid_n == !$past(ack_c, 3))
        else $error("autovector wrong");
    a_ack_sync: assert property ($fell(level5_ack_n) |-> $past(ack_c, 3) && !autovector_valid_n)
        else $error("ack wrong");
    cover property (!scc_cs_n && !scc_rd_n);
    cover property (!scc_rd_n && !scc_wr_n);
    cover property ($fell(level5_ack_n));
endmodule : spg_glue_assertions
bind spg_glue spg_glue_assertions spg_glue_assertions_i (.*);
`default_nettype wire

// ---- spg_host.sv ----
// Processor bus model that drives the glue's processor pins.
`timescale 1ns/1ps
`default_nettype none
module spg_host
    import spg_pkg::*;
(
    input wire logic pclk,
    input wire logic priority_line0_n,
    input wire logic priority_line1_n,
    input wire logic priority_line2_n,
    input wire logic autovector_valid_n,
    output logic cpu_as_n,
    output logic cpu_read,
    output logic [2:0] cpu_fc,
    output logic [23:1] cpu_addr,
    output logic strobe_timing_phase
);
    // The bench raises this only while it issues no cycles of its own.
    logic ack_en = 1'b0;
    initial
    begin
        cpu_as_n = 1'b1;
        cpu_read = 1'b0;
        cpu_fc = 3'h0;
        cpu_addr = 23'h0;
        strobe_timing_phase = 1'b0;
    end
    task automatic cyc(input logic a_n, input logic r, input logic [2:0] f,
        input logic [23:1] a, input logic p);
        @(posedge pclk);
        cpu_as_n <= a_n;
        cpu_read <= r;
        cpu_fc <= f;
        cpu_addr <= a;
        strobe_timing_phase <= p;
    endtask : cyc
    always @(posedge pclk)
        if (ack_en && {priority_line2_n, priority_line1_n, priority_line0_n} == 3'h2)
        begin
            cyc(1'b0, 1'b1, SPG_FC_CPU_SPACE, {20'h0, SPG_IRQ_LEVEL}, 1'b0);
            // The vector fetch at four times the vector number happens off this bus.
            repeat (20) if (autovector_valid_n !== 1'b0) @(posedge pclk);
            repeat (6) @(posedge pclk);
            cyc(1'b1, 1'b0, 3'h0, 23'h0, 1'b0);
        end
endmodule : spg_host
`default_nettype wire

// ---- spg_glue_bench.sv ----
// Self-checking bench for the serial port glue logic.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module spg_glue_bench
    import spg_pkg::*;
;
    localparam int BASE = 325;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h8B8C, v, r;
    logic cpu_as_n, cpu_read, strobe_timing_phase, scc_int_n = 1, board_reset_line = 0;
    logic [2:0] cpu_fc;
    logic [23:1] cpu_addr;
    logic ext_chan_a_clock = 0, ext_chan_b_clock = 0, scc_cs_n, scc_rd_n, scc_wr_n;
    logic channel_select_addr_bit, data_control_addr_bit, autovector_valid_n, level5_ack_n;
    logic priority_line0_n, priority_line1_n, priority_line2_n, chan_a_clk, chan_b_clk;
    logic [32:0] q[$], e;
    int mismatches = 0, total_checks = 0, n;
    spg_glue spg_glue_i (.*);
    spg_host spg_host_i (.*);
    initial forever #2.5 pclk = ~pclk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        repeat (50) if (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdx(input logic [7:0] a, input logic [32:0] x);
        q.push_back(x);
        apb(1'b0, a, 32'h0);
    endtask : rdx
    // Two edges are skipped first, since the edge after a change of setting may be short.
    task automatic half(input logic b, output int c);
        logic s;
        c = 0;
        repeat (2)
        begin
            s = b ? chan_b_clk : chan_a_clk;
            repeat (3000) if ((b ? chan_b_clk : chan_a_clk) === s) @(posedge pclk);
        end
        s = b ? chan_b_clk : chan_a_clk;
        repeat (3000)
        begin
            @(posedge pclk);
            c++;
            if ((b ? chan_b_clk : chan_a_clk) !== s) break;
        end
    endtask : half
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            e = q.pop_front();
            `CHK({pslverr, prdata}, e)
        end
    initial
    begin
        #400000;
        mismatches++;
        complete_run();
    end
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdx(SPG_STATUS_OFFSET, 33'h0);
        rdx(SPG_CFG_OFFSET, 33'h0);
        rdx(8'h08, {1'b1, 32'h0});
        v = rnd();
        apb(1'b1, SPG_CFG_OFFSET, v);
        rdx(SPG_STATUS_OFFSET, {17'h0, v[7:0], 8'h00});
        $display("registers done");
        repeat (300)
        begin
            r = rnd();
            spg_host_i.cyc(r[0], r[1], r[4:2], {r[5] ? SPG_WINDOW_HI : r[13:6], r[28:14]}, r[29]);
        end
        spg_host_i.cyc(1'b0, 1'b1, SPG_FC_SUP_DATA, {SPG_WINDOW_HI, 15'h0003}, 1'b1);
        repeat (4) @(posedge pclk);
        `CHK(scc_rd_n, 1'b0)
        `CHK(channel_select_addr_bit, 1'b1)
        `CHK(data_control_addr_bit, 1'b1)
        spg_host_i.cyc(1'b0, 1'b1, 3'h1, {SPG_WINDOW_HI, 15'h0003}, 1'b1);
        repeat (4) @(posedge pclk);
        `CHK(scc_cs_n, 1'b1)
        spg_host_i.cyc(1'b1, 1'b0, 3'h0, 23'h0, 1'b0);
        board_reset_line <= 1'b1;
        repeat (5) @(posedge pclk);
        `CHK({scc_rd_n, scc_wr_n}, 2'h0)
        board_reset_line <= 1'b0;
        $display("decode done");
        spg_host_i.ack_en = 1'b1;
        scc_int_n <= 1'b0;
        repeat (50) if (level5_ack_n !== 1'b0) @(posedge pclk);
        `CHK(level5_ack_n, 1'b0)
        scc_int_n <= 1'b1;
        repeat (30) @(posedge pclk);
        spg_host_i.ack_en = 1'b0;
        `CHK({priority_line2_n, priority_line1_n, priority_line0_n}, 3'h7)
        rdx(SPG_STATUS_OFFSET, {17'h0, v[7:0], 8'h00});
        $display("interrupt done");
        apb(1'b1, SPG_CFG_OFFSET, 32'h34);
        half(1'b0, n);
        `CHK(n, SPG_ASYNC_HALF_CYC)
        ext_chan_b_clock <= 1'b1;
        repeat (5) @(posedge pclk);
        `CHK(chan_b_clk, 1'b1)
        for (int k = 0; k < 2; k++)
        begin
            apb(1'b1, SPG_CFG_OFFSET, {24'h0, k[2:0], 5'h09});
            half(1'b0, n);
            `CHK(n, BASE << k)
            half(1'b1, n);
            `CHK(n, SPG_ASYNC_HALF_CYC)
        end
        apb(1'b1, SPG_CFG_OFFSET, 32'h00);
        ext_chan_a_clock <= 1'b1;
        repeat (5) @(posedge pclk);
        `CHK(chan_a_clk, 1'b1)
        apb(1'b1, SPG_CFG_OFFSET, 32'h0F);
        repeat (5) @(posedge pclk);
        `CHK({chan_a_clk, chan_b_clk}, 2'h0)
        $display("clocks done");
        complete_run();
    end
endmodule : spg_glue_bench
`default_nettype wire
